// >>> inc/eem_cfg.svh
// Offsets, field positions, reset values and timing of the serial memory host
`ifndef EEM_CFG_SVH
`define EEM_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define EEM_CLK_MHZ        200
// Quarter of one serial bit at 400 kHz, least time
`define EEM_T_QTR_NS       625
`define EEM_QTR_CYC        ((`EEM_T_QTR_NS * `EEM_CLK_MHZ + 999) / 1000)

// ****************************************
// Register map, byte addresses
// ****************************************
`define EEM_AW             5
`define EEM_A_CTRL         5'h00
`define EEM_A_ADDR         5'h04
`define EEM_A_DATA         5'h08
`define EEM_A_STAT         5'h0C
`define EEM_A_CFG          5'h10

// ****************************************
// Fields
// ****************************************
`define EEM_CTRL_GO        0
`define EEM_CTRL_OP_LSB    1
`define EEM_CTRL_OP_MSB    2
`define EEM_ADDR_MSB       18
`define EEM_ADDR_BS        16
`define EEM_ADDR_CSL       17
`define EEM_ADDR_CSH       18
`define EEM_DATA_MSB       7
`define EEM_ST_BUSY        0
`define EEM_ST_NACK        1
`define EEM_ST_DONE        2
`define EEM_CFG_CSL        0
`define EEM_CFG_CSH        1
`define EEM_CFG_WP         2
`define EEM_CFG_TYPE_LSB   4
`define EEM_CFG_TYPE_MSB   7

// ****************************************
// Reset values and bit-level constants
// ****************************************
`define EEM_CSL_RST        1'h0
`define EEM_CSH_RST        1'h0
`define EEM_WP_RST         1'h1
`define EEM_RW_READ        1'h1
`define EEM_RW_WRITE       1'h0
`define EEM_ACK_BIT        4'h8

`endif

// >>> inc/eem_pkg.sv
// Types shared by the serial memory host and its bit engine
package eem_pkg;

	// ****************************************
	// Software operations
	// ****************************************
	typedef enum logic [1:0] {EEM_OP_WRITE, EEM_OP_RAND_RD, EEM_OP_CUR_RD, EEM_OP_POLL} eem_op_t;

	// ****************************************
	// Bit engine commands and results
	// ****************************************
	typedef enum logic [1:0] {EEM_BOP_START, EEM_BOP_STOP, EEM_BOP_WR, EEM_BOP_RD} eem_bop_t;

	typedef struct packed {
		eem_bop_t   bop;
		logic [7:0] data;
		logic       nack;
	} eem_bcmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       nack;
	} eem_bres_t;

	// ****************************************
	// State machines
	// ****************************************
	typedef enum logic [1:0] {E_IDLE, E_FREE, E_RUN} eem_eng_st_t;

	typedef enum logic [3:0] {
		M_IDLE, M_START, M_CB, M_AH, M_AL, M_WD, M_RS, M_CB2, M_RD, M_STOP
	} eem_seq_st_t;

endpackage

// >>> src/eem_bit_eng.sv
// Bit engine: Start, Stop, byte write and byte read on the two-wire bus
`include "eem_cfg.svh"
module eem_bit_eng import eem_pkg::*; #(
	parameter int unsigned QTR_CYC = `EEM_QTR_CYC
) (
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	// Command and result
	input  wire logic      cmd_valid_i,
	input  wire eem_bcmd_t cmd_i,
	output logic           cmd_ready_o,
	output logic           res_valid_o,
	output eem_bres_t      res_o,
	// Bus pins, open drain
	input  wire logic      scl_i,
	output logic           scl_o,
	output logic           scl_oe_o,
	input  wire logic      sda_i,
	output logic           sda_o,
	output logic           sda_oe_o
);
	localparam int unsigned TW = $clog2(QTR_CYC + 1);

	// Two synchroniser stages need time to settle inside one quarter
	if (QTR_CYC < 4) begin : g_chk
		$error("QTR_CYC must be at least 4");
	end

	logic          scl_m_q, scl_s_q, sda_m_q, sda_s_q;
	logic [TW-1:0] tmr_q;
	logic          tick;
	eem_eng_st_t   st_q;
	logic [1:0]    ph_q;
	logic [3:0]    bit_q;
	eem_bcmd_t     cur_q;
	logic [7:0]    sh_q;
	logic          ack_q, own_q, scl_low_q, sda_low_q, res_v_q, tx;
	eem_bres_t     res_q;
	logic [1:0]    drv;

	// Line levels per phase: {scl low, sda low}
	function automatic logic [1:0] lines(eem_bop_t op, logic [1:0] ph, logic t);
		lines = 2'h0;
		unique case (op)
			EEM_BOP_START: lines = (ph == 2'h0) ? 2'h2 : (ph == 2'h1) ? 2'h0 :
				(ph == 2'h2) ? 2'h1 : 2'h3;
			EEM_BOP_STOP:  lines = (ph == 2'h0) ? 2'h3 : (ph == 2'h1) ? 2'h1 : 2'h0;
			EEM_BOP_WR,
			EEM_BOP_RD:    lines = {(ph == 2'h0) || (ph == 2'h3), ~t};
		endcase
	endfunction

	always_comb begin
		if (bit_q == `EEM_ACK_BIT) begin
			tx = (cur_q.bop == EEM_BOP_RD) ? cur_q.nack : 1'h1;
		end else begin
			tx = (cur_q.bop == EEM_BOP_WR) ? sh_q[7] : 1'h1;
		end
	end

	assign drv         = lines(cur_q.bop, ph_q, tx);
	assign tick        = (tmr_q == TW'(QTR_CYC - 1));
	assign cmd_ready_o = (st_q == E_IDLE);
	assign res_valid_o = res_v_q;
	assign res_o       = res_q;
	assign scl_o       = 1'h0;
	assign sda_o       = 1'h0;
	assign scl_oe_o    = scl_low_q;
	assign sda_oe_o    = sda_low_q;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_m_q <= 1'h1;
			scl_s_q <= 1'h1;
			sda_m_q <= 1'h1;
			sda_s_q <= 1'h1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
		end
	end

	// ****************************************
	// Quarter timer; in E_FREE it counts only while the bus is idle
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tmr_q <= '0;
		end else if (st_q == E_RUN || (st_q == E_FREE && scl_s_q && sda_s_q)) begin
			tmr_q <= tick ? '0 : tmr_q + TW'(1);
		end else begin
			tmr_q <= '0;
		end
	end

	// ****************************************
	// Pin drivers, one cycle behind the phase
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_low_q <= 1'h0;
			sda_low_q <= 1'h0;
		end else if (st_q == E_RUN) begin
			scl_low_q <= drv[1];
			sda_low_q <= drv[0];
		end
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q    <= E_IDLE;
			ph_q    <= 2'h0;
			bit_q   <= 4'h0;
			cur_q   <= '0;
			sh_q    <= 8'h00;
			ack_q   <= 1'h0;
			own_q   <= 1'h0;
			res_v_q <= 1'h0;
			res_q   <= '0;
		end else begin
			res_v_q <= 1'h0;
			unique case (st_q)
				E_IDLE: if (cmd_valid_i) begin
					cur_q <= cmd_i;
					sh_q  <= cmd_i.data;
					bit_q <= 4'h0;
					ph_q  <= 2'h0;
					ack_q <= 1'h0;
					st_q  <= (cmd_i.bop == EEM_BOP_START && !own_q) ? E_FREE : E_RUN;
				end
				E_FREE: if (tick) begin
					st_q <= E_RUN;
				end
				E_RUN: if (tick) begin
					ph_q <= ph_q + 2'h1;
					if (ph_q == 2'h2) begin
						if (cur_q.bop == EEM_BOP_WR && bit_q == `EEM_ACK_BIT) begin
							ack_q <= sda_s_q;
						end else if (cur_q.bop == EEM_BOP_RD && bit_q != `EEM_ACK_BIT) begin
							sh_q <= {sh_q[6:0], sda_s_q};
						end
					end
					if (ph_q == 2'h3) begin
						if ((cur_q.bop == EEM_BOP_WR || cur_q.bop == EEM_BOP_RD)
							&& bit_q != `EEM_ACK_BIT) begin
							bit_q <= bit_q + 4'h1;
							if (cur_q.bop == EEM_BOP_WR) begin
								sh_q <= {sh_q[6:0], 1'h0};
							end
						end else begin
							st_q       <= E_IDLE;
							res_v_q    <= 1'h1;
							res_q.data <= sh_q;
							res_q.nack <= ack_q;
							if (cur_q.bop == EEM_BOP_START) begin
								own_q <= 1'h1;
							end else if (cur_q.bop == EEM_BOP_STOP) begin
								own_q <= 1'h0;
							end
						end
					end
				end
				default: st_q <= E_IDLE;
			endcase
		end
	end

endmodule

// >>> src/eem_ctrl.sv
// Host controller for a two-wire serial memory, driven over Avalon-MM
// ****************************************
// Serial memory host
// ****************************************
`include "eem_cfg.svh"
module eem_ctrl import eem_pkg::*; #(
	parameter int unsigned QTR_CYC  = `EEM_QTR_CYC,
	// Reset value of the device-type code field; value is arbitrary
	parameter logic [3:0]  TYPE_RST = 4'h5
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Avalon-MM slave
	input  wire logic [`EEM_AW-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic [31:0]            avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// Serial clock, open drain
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe_o,
	// Serial data, open drain
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	// Device straps
	output logic                   chip_select_pin_low_o,
	output logic                   chip_select_pin_high_o,
	output logic                   fixed_select_strap_o,
	output logic                   wp_o
);

	// ****************************************
	// Declarations
	// ****************************************
	logic                   ack_q;
	logic                   req;
	logic                   acc;
	logic                   busy;
	logic [31:0]            rdata_d;
	logic [31:0]            rdata_q;
	logic [31:0]            merged;
	eem_op_t                op_q;
	logic [`EEM_ADDR_MSB:0] addr_q;
	logic [7:0]             wdata_q;
	logic [7:0]             rbyte_q;
	logic                   nack_q;
	logic                   done_q;
	logic                   csl_q;
	logic                   csh_q;
	logic                   wp_q;
	logic                   strap_q;
	logic [3:0]             type_q;
	eem_seq_st_t            seq_q;
	logic                   issued_q;
	logic                   go;
	logic                   done_clr;
	logic                   bcmd_valid;
	logic                   bcmd_ready;
	eem_bcmd_t              bcmd;
	logic                   bres_valid;
	eem_bres_t              bres;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic hit(logic [`EEM_AW-1:0] a, logic [`EEM_AW-1:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw,
		logic [3:0] be);
		be_merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				be_merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// Control byte: type code, block select, chip selects, direction
	function automatic logic [7:0] cbyte(logic [3:0] t, logic [`EEM_ADDR_MSB:0] a,
		logic rw);
		cbyte = {t, a[`EEM_ADDR_BS], a[`EEM_ADDR_CSH], a[`EEM_ADDR_CSL], rw};
	endfunction

	// ****************************************
	// Avalon-MM slave: one wait state per access
	// ****************************************
	assign req               = avs_read_i || avs_write_i;
	assign acc               = req && ack_q;
	assign avs_waitrequest_o = req && !ack_q;
	assign avs_readdata_o    = rdata_q;
	assign busy              = (seq_q != M_IDLE);

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit(avs_address_i, `EEM_A_CTRL)) begin
			rdata_d[`EEM_CTRL_OP_MSB:`EEM_CTRL_OP_LSB] = op_q;
		end else if (hit(avs_address_i, `EEM_A_ADDR)) begin
			rdata_d[`EEM_ADDR_MSB:0] = addr_q;
		end else if (hit(avs_address_i, `EEM_A_DATA)) begin
			rdata_d[`EEM_DATA_MSB:0] = rbyte_q;
		end else if (hit(avs_address_i, `EEM_A_STAT)) begin
			rdata_d[`EEM_ST_BUSY] = busy;
			rdata_d[`EEM_ST_NACK] = nack_q;
			rdata_d[`EEM_ST_DONE] = done_q;
		end else if (hit(avs_address_i, `EEM_A_CFG)) begin
			rdata_d[`EEM_CFG_CSL] = csl_q;
			rdata_d[`EEM_CFG_CSH] = csh_q;
			rdata_d[`EEM_CFG_WP]  = wp_q;
			rdata_d[`EEM_CFG_TYPE_MSB:`EEM_CFG_TYPE_LSB] = type_q;
		end
	end

	assign merged   = be_merge(rdata_d, avs_writedata_i, avs_byteenable_i);
	assign go       = acc && avs_write_i && hit(avs_address_i, `EEM_A_CTRL)
		&& avs_byteenable_i[0] && avs_writedata_i[`EEM_CTRL_GO] && !busy;
	assign done_clr = acc && avs_write_i && hit(avs_address_i, `EEM_A_STAT)
		&& avs_byteenable_i[0] && avs_writedata_i[`EEM_ST_DONE];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q   <= 1'h0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req && !ack_q;
			if (avs_read_i && !ack_q) begin
				rdata_q <= rdata_d;
			end
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	// Setup is frozen while an operation runs so the straps never move mid-transfer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_q    <= EEM_OP_WRITE;
			addr_q  <= '0;
			wdata_q <= 8'h00;
			csl_q   <= `EEM_CSL_RST;
			csh_q   <= `EEM_CSH_RST;
			wp_q    <= `EEM_WP_RST;
			type_q  <= TYPE_RST;
		end else if (acc && avs_write_i && !busy) begin
			if (hit(avs_address_i, `EEM_A_CTRL) && avs_byteenable_i[0]) begin
				op_q <= eem_op_t'(merged[`EEM_CTRL_OP_MSB:`EEM_CTRL_OP_LSB]);
			end
			if (hit(avs_address_i, `EEM_A_ADDR)) begin
				addr_q <= merged[`EEM_ADDR_MSB:0];
			end
			if (hit(avs_address_i, `EEM_A_DATA)) begin
				wdata_q <= merged[`EEM_DATA_MSB:0];
			end
			if (hit(avs_address_i, `EEM_A_CFG)) begin
				csl_q  <= merged[`EEM_CFG_CSL];
				csh_q  <= merged[`EEM_CFG_CSH];
				wp_q   <= merged[`EEM_CFG_WP];
				type_q <= merged[`EEM_CFG_TYPE_MSB:`EEM_CFG_TYPE_LSB];
			end
		end
	end

	// ****************************************
	// Strap pins, from flip-flops so they are defined from reset
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_q <= 1'h0;
		end else begin
			strap_q <= 1'h1;
		end
	end

	assign chip_select_pin_low_o  = csl_q;
	assign chip_select_pin_high_o = csh_q;
	assign fixed_select_strap_o   = strap_q;
	assign wp_o                   = wp_q;

	// ****************************************
	// Status
	// ****************************************
	// A completion in the same cycle as a clear keeps the flag set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'h0;
		end else if (bres_valid && seq_q == M_STOP) begin
			done_q <= 1'h1;
		end else if (done_clr) begin
			done_q <= 1'h0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nack_q  <= 1'h0;
			rbyte_q <= 8'h00;
		end else if (go) begin
			nack_q <= 1'h0;
		end else if (bres_valid) begin
			unique case (seq_q)
				M_CB, M_AH, M_AL, M_WD, M_CB2: if (bres.nack) begin
					nack_q <= 1'h1;
				end
				M_RD: rbyte_q <= bres.data;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	always_comb begin
		bcmd      = '0;
		bcmd.bop  = EEM_BOP_START;
		bcmd.data = 8'h00;
		bcmd.nack = 1'h0;
		unique case (seq_q)
			M_IDLE, M_START, M_RS: bcmd.bop = EEM_BOP_START;
			M_CB: begin
				bcmd.bop  = EEM_BOP_WR;
				bcmd.data = cbyte(type_q, addr_q, `EEM_RW_WRITE);
			end
			M_AH: begin
				bcmd.bop  = EEM_BOP_WR;
				bcmd.data = addr_q[15:8];
			end
			M_AL: begin
				bcmd.bop  = EEM_BOP_WR;
				bcmd.data = addr_q[7:0];
			end
			M_WD: begin
				bcmd.bop  = EEM_BOP_WR;
				bcmd.data = wdata_q;
			end
			M_CB2: begin
				bcmd.bop  = EEM_BOP_WR;
				bcmd.data = cbyte(type_q, addr_q, `EEM_RW_READ);
			end
			M_RD: begin
				bcmd.bop  = EEM_BOP_RD;
				bcmd.nack = 1'h1;
			end
			M_STOP: bcmd.bop = EEM_BOP_STOP;
		endcase
	end

	assign bcmd_valid = busy && !issued_q;

	// Any refused byte ends the operation with a Stop at once
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seq_q    <= M_IDLE;
			issued_q <= 1'h0;
		end else begin
			if (bcmd_valid && bcmd_ready) begin
				issued_q <= 1'h1;
			end else if (bres_valid) begin
				issued_q <= 1'h0;
			end
			if (go) begin
				seq_q <= M_START;
			end else if (bres_valid) begin
				unique case (seq_q)
					M_START: seq_q <= (op_q == EEM_OP_CUR_RD) ? M_CB2 : M_CB;
					M_CB: begin
						if (bres.nack || op_q == EEM_OP_POLL) begin
							seq_q <= M_STOP;
						end else begin
							seq_q <= M_AH;
						end
					end
					M_AH: seq_q <= bres.nack ? M_STOP : M_AL;
					M_AL: begin
						if (bres.nack || op_q == EEM_OP_WRITE) begin
							seq_q <= bres.nack ? M_STOP : M_WD;
						end else begin
							seq_q <= M_RS;
						end
					end
					M_WD:  seq_q <= M_STOP;
					M_RS:  seq_q <= M_CB2;
					M_CB2: seq_q <= bres.nack ? M_STOP : M_RD;
					M_RD:  seq_q <= M_STOP;
					M_STOP: seq_q <= M_IDLE;
					default: seq_q <= M_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Bit engine
	// ****************************************
	eem_bit_eng #(
		.QTR_CYC (QTR_CYC)
	) u_eng (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.cmd_valid_i (bcmd_valid),
		.cmd_i       (bcmd),
		.cmd_ready_o (bcmd_ready),
		.res_valid_o (bres_valid),
		.res_o       (bres),
		.scl_i       (scl_i),
		.scl_o       (scl_o),
		.scl_oe_o    (scl_oe_o),
		.sda_i       (sda_i),
		.sda_o       (sda_o),
		.sda_oe_o    (sda_oe_o)
	);

endmodule

// >>> testbench/eem_ctrl_bench.sv
// Self-checking bench of the serial memory host with a device model on the bus
`include "eem_cfg.svh"
module eem_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'h0, rst_n_i = 1'h0, prog = 1'h0;
	logic [3:0]  be = 4'hF;
	logic [4:0]  avs_address_i = 5'h0;
	logic        avs_read_i = 1'h0, avs_write_i = 1'h0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic        avs_waitrequest_o, scl_oe, sda_oe, pull, csl, csh, fixed, wp, scl_o, sda_o;
	wire         scl_w = !scl_oe;
	wire         sda_w = !(sda_oe || pull);
	int          n_errors = 0, cmp_count = 0, cyc = 0;
	eem_ctrl #(.QTR_CYC(4)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(be),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe),
		.chip_select_pin_low_o(csl), .chip_select_pin_high_o(csh),
		.fixed_select_strap_o(fixed), .wp_o(wp));
	eem_dev_model dev_u (.scl_i(scl_w), .sda_i(sda_w), .csl_i(csl), .csh_i(csh),
		.fixed_i(fixed), .wp_i(wp), .prog_i(prog), .pull_o(pull));
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 50000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Holds the request until waitrequest is seen low, then lets one edge pass
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'h0);
		q = avs_readdata_o;
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic op(input logic [31:0] cfg, adr, dat, ctl, output logic [31:0] st, rd);
		logic [31:0] q;
		bus(1'h1, `EEM_A_CFG, cfg, q);
		bus(1'h1, `EEM_A_ADDR, adr, q);
		bus(1'h1, `EEM_A_DATA, dat, q);
		bus(1'h1, `EEM_A_CTRL, ctl, q);
		bus(1'h0, `EEM_A_STAT, 32'h0, st);
		chk("busy after go", 32'h1, st & 32'h1);
		do bus(1'h0, `EEM_A_STAT, 32'h0, st); while (st[`EEM_ST_DONE] !== 1'h1);
		chk("busy at done", 32'h0, st & 32'h1);
		bus(1'h1, `EEM_A_STAT, 32'h4, q);
		bus(1'h0, `EEM_A_DATA, 32'h0, rd);
	endtask
	task automatic t_reset;
		logic [31:0] q;
		bus(1'h0, `EEM_A_CFG, 32'h0, q);
		chk("cfg", 32'h54, q);
		chk("pins", 32'hC, {28'h0, fixed, wp, csh, csl});
		bus(1'h1, 5'h14, 32'hFF, q);
		bus(1'h0, 5'h14, 32'h0, q);
		chk("unmapped", 32'h0, q);
		// No byte lane enabled: the write must leave the setup untouched
		be <= 4'h0;
		bus(1'h1, `EEM_A_CFG, 32'hFF, q);
		be <= 4'hF;
		bus(1'h0, `EEM_A_CFG, 32'h0, q);
		chk("masked cfg", 32'h54, q);
		// Open-drain pins only ever pull low
		chk("drive levels", 32'h0, {30'h0, scl_o, sda_o});
		$display("reset test done");
	endtask
	task automatic t_xfer;
		logic [31:0] st, d;
		op(32'h51, 32'h3_2345, 32'hA5, 32'h1, st, d);
		chk("write nack", 32'h0, st & 32'h2);
		chk("csl pin", 32'h1, {31'h0, csl});
		op(32'h51, 32'h3_2345, 32'h0, 32'h3, st, d);
		chk("random read", 32'hA5, d);
		$display("transfer test done");
	endtask
	task automatic t_segment;
		logic [31:0] st, d;
		op(32'h51, 32'h3_0000, 32'h11, 32'h1, st, d);
		op(32'h51, 32'h2_0000, 32'h22, 32'h1, st, d);
		op(32'h51, 32'h3_FFFF, 32'h77, 32'h1, st, d);
		op(32'h51, 32'h3_FFFF, 32'h0, 32'h3, st, d);
		chk("segment end", 32'h77, d);
		op(32'h51, 32'h3_FFFF, 32'h0, 32'h5, st, d);
		chk("segment wrap", 32'h11, d);
		$display("segment test done");
	endtask
	task automatic t_protect;
		logic [31:0] st, d;
		op(32'h55, 32'h3_2345, 32'h3C, 32'h1, st, d);
		chk("protected nack", 32'h0, st & 32'h2);
		chk("wp pin", 32'h1, {31'h0, wp});
		op(32'h55, 32'h3_2345, 32'h0, 32'h3, st, d);
		chk("protected data", 32'hA5, d);
		$display("protect test done");
	endtask
	task automatic t_select;
		logic [31:0] st, d;
		op(32'h51, 32'h7_2345, 32'h1, 32'h1, st, d);
		chk("chip select", 32'h2, st & 32'h2);
		op(32'h61, 32'h3_2345, 32'h1, 32'h1, st, d);
		chk("type code", 32'h2, st & 32'h2);
		$display("select test done");
	endtask
	task automatic t_poll;
		logic [31:0] st, d;
		prog <= 1'h1;
		op(32'h51, 32'h3_2345, 32'h0, 32'h7, st, d);
		chk("poll busy", 32'h2, st & 32'h2);
		prog <= 1'h0;
		op(32'h51, 32'h3_2345, 32'h0, 32'h7, st, d);
		chk("poll free", 32'h0, st & 32'h2);
		$display("poll test done");
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		t_reset();
		t_xfer();
		t_segment();
		t_protect();
		t_select();
		t_poll();
		print_verdict();
	end
endmodule

// >>> testbench/eem_ctrl_properties.sv
// Port checker of the serial memory host, bound to its top module
module eem_ctrl_chk #(
	parameter int unsigned QTR_CYC = 4
) (
	// Clock, reset and bus handshake
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// Two-wire pins and straps
	input wire logic scl_i,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_oe_o,
	input wire logic chip_select_pin_low_o,
	input wire logic chip_select_pin_high_o,
	input wire logic fixed_select_strap_o,
	input wire logic wp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QB = QTR_CYC + 2;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("bus access took more than one wait state");
	AST_START_IDLE: assert property ($rose(sda_oe_o) && !scl_oe_o
		|-> $past(sda_i) && $past(scl_i)) else $error("start while bus not idle");
	AST_START_CLK: assert property ($rose(sda_oe_o) && !scl_oe_o
		|-> ##[1:QB] $rose(scl_oe_o)) else $error("no clock low after start");
	AST_STOP_IDLE: assert property ($fell(sda_oe_o) && !scl_oe_o && !$past(scl_oe_o)
		|-> (!scl_oe_o && !sda_oe_o) [*3]) else $error("bus not left idle after stop");
	AST_DATA_STABLE: assert property ($fell(scl_oe_o)
		|=> $stable(sda_oe_o) [*3]) else $error("data moved while clock high");
	AST_CLK_HIGH: assert property ($fell(scl_oe_o)
		|=> !scl_oe_o [*3]) else $error("clock high period too short");
	AST_FIXED_HIGH: assert property ($past(rst_n_i)
		|-> fixed_select_strap_o) else $error("fixed select strap not high");
	AST_STRAP_HOLD: assert property (scl_oe_o |-> $stable({chip_select_pin_low_o,
		chip_select_pin_high_o, wp_o})) else $error("strap moved during a transfer");
	cover property ($rose(sda_oe_o) && !scl_oe_o);
	cover property ($fell(sda_oe_o) && !scl_oe_o && !$past(scl_oe_o));
	cover property ($fell(wp_o));
endmodule

bind eem_ctrl eem_ctrl_chk #(.QTR_CYC(QTR_CYC)) chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.scl_i(scl_i), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
	.chip_select_pin_low_o(chip_select_pin_low_o), .chip_select_pin_high_o(chip_select_pin_high_o),
	.fixed_select_strap_o(fixed_select_strap_o), .wp_o(wp_o));

// >>> testbench/eem_dev_model.sv
// Behavioural model of the serial memory device on the two-wire bus
module eem_dev_model #(
	// Device-type code; value is arbitrary
	parameter logic [3:0] TYPE = 4'h5
) (
	// Bus and strap levels
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic csl_i,
	input  wire logic csh_i,
	input  wire logic fixed_i,
	input  wire logic wp_i,
	// Programming cycle in progress, set by the bench
	input  wire logic prog_i,
	// High pulls the data line low
	output logic      pull_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [logic [16:0]];
	logic [16:0] ptr = 17'h0;
	logic [7:0]  sh = 8'h0, wcb = 8'h0, pdat = 8'h0;
	logic        act = 1'h0, rdm = 1'h0, pend = 1'h0;
	int          bn = 0, byt = 0;
	initial pull_o = 1'h0;
	always @(negedge sda_i) if (scl_i === 1'h1) begin
		act = 1'h1; rdm = 1'h0; bn = 0; byt = 0; pull_o = 1'h0;
	end
	always @(posedge sda_i) if (scl_i === 1'h1) begin
		act = 1'h0; rdm = 1'h0; pull_o = 1'h0;
		if (pend && !wp_i) mem[ptr] = pdat;
		if (pend) ptr[15:0] = ptr[15:0] + 16'h1;
		pend = 1'h0;
	end
	always @(posedge scl_i) if (act) begin
		if (rdm) bn++;
		else if (bn < 8) begin sh = {sh[6:0], sda_i}; bn++; end
	end
	// Pull only moves after clock falls, so it never fakes a start or stop
	always @(negedge scl_i) if (act) begin
		if (rdm) begin
			pull_o = (bn < 8) ? !sh[7 - bn] : 1'h0;
			if (bn == 9) begin act = 1'h0; rdm = 1'h0; end
		end else if (bn == 8) begin
			bn = 9;
			if (byt == 0) begin
				act = sh[7:4] == TYPE && sh[2:1] == {csh_i, csl_i} && fixed_i
					&& !(prog_i && sh == wcb);
				ptr[16] = sh[3];
				if (act && !sh[0]) wcb = sh;
			end else if (byt == 1) ptr[15:8] = sh;
			else if (byt == 2) ptr[7:0] = sh;
			else begin pdat = sh; pend = 1'h1; end
			byt++;
			pull_o = act;
		end else if (bn == 9) begin
			bn = 0;
			pull_o = 1'h0;
			if (sh[0] && byt == 1) begin
				rdm = 1'h1;
				sh = mem.exists(ptr) ? mem[ptr] : 8'hFF;
				ptr[15:0] = ptr[15:0] + 16'h1;
				pull_o = !sh[7];
			end
		end
	end
endmodule
